// ### logic/object_ctrl_defs.svh
// register map, field positions, reset values and timing figures for object control
`ifndef OBJECT_CTRL_DEFS_SVH
`define OBJECT_CTRL_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define OC_CLK_PERIOD_NS 25
`define OC_TICK_MS 10
`define OC_NS_PER_MS 1000000

// ****************************************
// register byte addresses
// ****************************************
`define OC_ADDR_CTRL 8'h00
`define OC_ADDR_TRAVERSE 8'h04
`define OC_ADDR_SYNC_WAIT 8'h08
`define OC_ADDR_CLOSE_MAX 8'h0c
`define OC_ADDR_OPEN_MAX 8'h10
`define OC_ADDR_TERM 8'h14
`define OC_ADDR_FT_LEN 8'h18
`define OC_ADDR_STATUS 8'h1c
`define OC_ADDR_OPEN_MASK 8'h20
`define OC_ADDR_CLOSE_MASK 8'h24

// ****************************************
// control and status fields
// ****************************************
`define OC_CTRL_SYNC_BIT 0
`define OC_CTRL_RDY_LSB 1
`define OC_CTRL_ACC_LSB 3
`define OC_STAT_BRK_LSB 0
`define OC_STAT_STATE_LSB 2
`define OC_STAT_FT_BIT 5
`define OC_STAT_ERR_BIT 6
`define OC_STAT_CANCEL_BIT 7

// ****************************************
// reset values, times in 10 ms ticks
// ****************************************
`define OC_CTRL_RST 5'h10
`define OC_TIME_RST 16'h0014
`define OC_TERM_RST 16'h03e8
`define OC_MASK_RST 8'h00

`endif

// ### logic/object_ctrl_pkg.sv
// types shared by the object control logic
package object_ctrl_pkg;

    typedef enum logic [1:0] {BRK_INTERMEDIATE, BRK_OPEN, BRK_CLOSED, BRK_BAD} brk_status_t;
    typedef enum logic [1:0] {RDY_OFF, RDY_HIGH, RDY_LOW, RDY_SPARE} ready_mode_t;
    typedef enum logic [1:0] {ACC_USER, ACC_OPERATOR, ACC_CONFIG, ACC_SUPER} access_t;
    typedef enum logic [2:0] {ST_IDLE, ST_SYNC_WAIT, ST_CLOSE_PULSE, ST_OPEN_PULSE,
        ST_WAIT_POS} ctrl_state_t;

endpackage : object_ctrl_pkg

// ### logic/position_monitor.sv
// breaker position decode with traverse supervision
`timescale 1ns/1ps
`default_nettype none
`include "object_ctrl_defs.svh"

module position_monitor
    import object_ctrl_pkg::*;
#(
    parameter int TW = 16
)
(
    input wire logic i_sys_clk, // system clock
    input wire logic i_rst_n, // async reset, low active
    input wire logic i_tick, // 10 ms enable
    input wire logic i_open_pos, // open contact
    input wire logic i_closed_pos, // closed contact
    input wire logic [TW-1:0] i_traverse, // traverse time in ticks
    output brk_status_t o_status // decoded breaker status
);

    logic [TW-1:0] cnt_reg, cnt_next;
    logic [1:0] prev_reg, prev_next;
    brk_status_t status_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        prev_next = {i_open_pos, i_closed_pos};
        status_next = o_status;
        if (i_open_pos != i_closed_pos)
        begin
            cnt_next = '0;
            status_next = i_open_pos ? BRK_OPEN : BRK_CLOSED;
        end
        else if (prev_reg != {i_open_pos, i_closed_pos})
        begin
            cnt_next = '0;
        end
        else
        begin
            // saturate one past the limit so the fault stays asserted
            if (i_tick && cnt_reg <= i_traverse)
            begin
                cnt_next = cnt_reg + 1'b1;
            end
            if (cnt_reg > i_traverse)
            begin
                status_next = i_open_pos ? BRK_BAD : BRK_INTERMEDIATE;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_reg <= '0;
            prev_reg <= 2'h0;
            o_status <= BRK_INTERMEDIATE;
        end
        else
        begin
            cnt_reg <= cnt_next;
            prev_reg <= prev_next;
            o_status <= status_next;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    property p_both_bad;
        i_open_pos && i_closed_pos && prev_reg == 2'h3 && cnt_reg > i_traverse |=> o_status == BRK_BAD;
    endproperty
    a_both_bad: assert property (p_both_bad) else $error("both contacts not reported bad");

    property p_none_inter;
        !i_open_pos && !i_closed_pos && prev_reg == 2'h0 && cnt_reg > i_traverse
            |=> o_status == BRK_INTERMEDIATE;
    endproperty
    a_none_inter: assert property (p_none_inter) else $error("no contact not intermediate");

    property p_open_pos;
        i_open_pos && !i_closed_pos |=> o_status == BRK_OPEN;
    endproperty
    a_open_pos: assert property (p_open_pos) else $error("open contact not reported open");

    property p_closed_pos;
        !i_open_pos && i_closed_pos |=> o_status == BRK_CLOSED;
    endproperty
    a_closed_pos: assert property (p_closed_pos) else $error("closed contact not closed");

endmodule : position_monitor
`default_nettype wire

// ### logic/object_control.sv
// open/close control of one switchgear object
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "object_ctrl_defs.svh"

module object_control
    import object_ctrl_pkg::*;
#(
    parameter int TICK_CYCLES = (`OC_TICK_MS * `OC_NS_PER_MS) / `OC_CLK_PERIOD_NS,
    parameter int NLOCK = 8,
    parameter int TW = 16
)
(
    input wire logic i_sys_clk, // 40 MHz clock
    input wire logic i_rst_n, // async reset, low active
    input wire logic [7:0] i_addr, // register byte address
    input wire logic [31:0] i_wr_data, // register write data
    input wire logic i_wr_en, // write strobe
    input wire logic i_rd_en, // read strobe
    output logic [31:0] o_rd_data, // read data, cycle after strobe
    input wire logic i_open_pos, // breaker open contact
    input wire logic i_closed_pos, // breaker closed contact
    input wire logic i_ready, // object ready
    input wire logic i_sync_ok, // synchrocheck permission
    input wire logic i_local_open, // local open button
    input wire logic i_local_close, // local close button
    input wire logic i_remote_open, // remote_telecontrol_unit open
    input wire logic i_remote_close, // remote_telecontrol_unit close
    input wire logic i_app_open, // application open
    input wire logic i_app_close, // application close
    input wire logic i_sld_open, // single_line_diagram_control open
    input wire logic i_sld_close, // single_line_diagram_control close
    input wire logic [1:0] i_sld_level, // operator access level
    input wire logic [NLOCK-1:0] i_open_lock, // open interlock sources
    input wire logic [NLOCK-1:0] i_close_lock, // close interlock sources
    input wire logic i_ar_in_control, // auto-recloser owns object
    input wire logic i_ar_reclose_expected, // further reclose pending
    output logic o_open_cmd, // first_output_relay open coil
    output logic o_close_cmd, // numbered_output_relay close coil
    output brk_status_t o_brk_status, // breaker status
    output logic o_final_trip, // final trip signal
    output logic o_ctrl_error, // termination timeout pulse
    output logic o_sync_cancel // sync timeout pulse
);

    // ****************************************
    // tick divider
    // ****************************************
    localparam int DW = $clog2(TICK_CYCLES);
    logic [DW-1:0] div_reg, div_next;
    logic tick_reg, tick_next;

    always_comb
    begin
        tick_next = (div_reg == DW'(TICK_CYCLES - 1));
        div_next = tick_next ? '0 : div_reg + 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [4:0] ctrl_reg, ctrl_next;
    logic [TW-1:0] trav_reg, trav_next, swait_reg, swait_next, cmax_reg, cmax_next;
    logic [TW-1:0] omax_reg, omax_next, term_reg, term_next, ftlen_reg, ftlen_next;
    logic [NLOCK-1:0] omask_reg, omask_next, cmask_reg, cmask_next;
    logic err_reg, err_next, cancel_reg, cancel_next;
    logic [31:0] rd_next;
    ctrl_state_t state_reg, state_next;

    logic use_sync;
    ready_mode_t rdy_mode;
    access_t acc_min;
    assign use_sync = ctrl_reg[`OC_CTRL_SYNC_BIT];
    assign rdy_mode = ready_mode_t'(ctrl_reg[`OC_CTRL_RDY_LSB +: 2]);
    assign acc_min = access_t'(ctrl_reg[`OC_CTRL_ACC_LSB +: 2]);

    function automatic logic [TW-1:0] wr_time(input logic hit, input logic [TW-1:0] cur,
        input logic [31:0] d);
        wr_time = hit ? d[TW-1:0] : cur;
    endfunction : wr_time

    always_comb
    begin
        ctrl_next = (i_wr_en && i_addr == `OC_ADDR_CTRL) ? i_wr_data[4:0] : ctrl_reg;
        trav_next = wr_time(i_wr_en && i_addr == `OC_ADDR_TRAVERSE, trav_reg, i_wr_data);
        swait_next = wr_time(i_wr_en && i_addr == `OC_ADDR_SYNC_WAIT, swait_reg, i_wr_data);
        cmax_next = wr_time(i_wr_en && i_addr == `OC_ADDR_CLOSE_MAX, cmax_reg, i_wr_data);
        omax_next = wr_time(i_wr_en && i_addr == `OC_ADDR_OPEN_MAX, omax_reg, i_wr_data);
        term_next = wr_time(i_wr_en && i_addr == `OC_ADDR_TERM, term_reg, i_wr_data);
        ftlen_next = wr_time(i_wr_en && i_addr == `OC_ADDR_FT_LEN, ftlen_reg, i_wr_data);
        omask_next = (i_wr_en && i_addr == `OC_ADDR_OPEN_MASK) ? i_wr_data[NLOCK-1:0] : omask_reg;
        cmask_next = (i_wr_en && i_addr == `OC_ADDR_CLOSE_MASK) ? i_wr_data[NLOCK-1:0] : cmask_reg;
        rd_next = 32'h0000_0000;
        if (!i_rd_en)
        begin
            rd_next = 32'h0000_0000;
        end
        else if (i_addr == `OC_ADDR_CTRL)
        begin
            rd_next[4:0] = ctrl_reg;
        end
        else if (i_addr == `OC_ADDR_TRAVERSE)
        begin
            rd_next[TW-1:0] = trav_reg;
        end
        else if (i_addr == `OC_ADDR_SYNC_WAIT)
        begin
            rd_next[TW-1:0] = swait_reg;
        end
        else if (i_addr == `OC_ADDR_CLOSE_MAX)
        begin
            rd_next[TW-1:0] = cmax_reg;
        end
        else if (i_addr == `OC_ADDR_OPEN_MAX)
        begin
            rd_next[TW-1:0] = omax_reg;
        end
        else if (i_addr == `OC_ADDR_TERM)
        begin
            rd_next[TW-1:0] = term_reg;
        end
        else if (i_addr == `OC_ADDR_FT_LEN)
        begin
            rd_next[TW-1:0] = ftlen_reg;
        end
        else if (i_addr == `OC_ADDR_STATUS)
        begin
            rd_next[`OC_STAT_BRK_LSB +: 2] = o_brk_status;
            rd_next[`OC_STAT_STATE_LSB +: 3] = state_reg;
            rd_next[`OC_STAT_FT_BIT] = o_final_trip;
            rd_next[`OC_STAT_ERR_BIT] = err_reg;
            rd_next[`OC_STAT_CANCEL_BIT] = cancel_reg;
        end
        else if (i_addr == `OC_ADDR_OPEN_MASK)
        begin
            rd_next[NLOCK-1:0] = omask_reg;
        end
        else if (i_addr == `OC_ADDR_CLOSE_MASK)
        begin
            rd_next[NLOCK-1:0] = cmask_reg;
        end
    end

    // ****************************************
    // request qualification
    // ****************************************
    logic open_req, close_req, open_q_reg, close_q_reg, open_rise, close_rise;
    logic open_blocked, close_blocked, ready_ok, close_ok, sld_ok;

    // interlock sources are whatever the bay wires in: other objects, functions, inputs
    assign open_blocked = |(i_open_lock & omask_reg);
    assign close_blocked = |(i_close_lock & cmask_reg);
    assign sld_ok = (i_sld_level >= acc_min);
    assign open_req = i_local_open | i_remote_open | i_app_open | (i_sld_open & sld_ok);
    assign close_req = i_local_close | i_remote_close | i_app_close | (i_sld_close & sld_ok);
    assign open_rise = open_req & ~open_q_reg;
    assign close_rise = close_req & ~close_q_reg;
    assign ready_ok = (rdy_mode == RDY_HIGH) ? i_ready :
        (rdy_mode == RDY_LOW) ? ~i_ready : 1'b1;
    assign close_ok = ready_ok && !close_blocked && (!use_sync || i_sync_ok);

    // ****************************************
    // control sequence
    // ****************************************
    logic [TW-1:0] pcnt_reg, pcnt_next, tcnt_reg, tcnt_next, fcnt_reg, fcnt_next;
    logic dir_open_reg, dir_open_next, ft_next, err_pulse, cancel_pulse, opened, closed;

    assign opened = (o_brk_status == BRK_OPEN);
    assign closed = (o_brk_status == BRK_CLOSED);

    always_comb
    begin
        state_next = state_reg;
        dir_open_next = dir_open_reg;
        pcnt_next = (tick_reg && pcnt_reg != '1) ? pcnt_reg + 1'b1 : pcnt_reg;
        tcnt_next = (tick_reg && tcnt_reg != '1) ? tcnt_reg + 1'b1 : tcnt_reg;
        err_pulse = 1'b0;
        cancel_pulse = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                pcnt_next = '0;
                tcnt_next = '0;
                // open wins a tie; blocked requests are simply dropped
                if (open_rise && !open_blocked)
                begin
                    state_next = ST_OPEN_PULSE;
                    dir_open_next = 1'b1;
                end
                else if (close_rise && !open_rise && !close_blocked && ready_ok)
                begin
                    dir_open_next = 1'b0;
                    state_next = (use_sync && !i_sync_ok) ? ST_SYNC_WAIT : ST_CLOSE_PULSE;
                end
            end
            ST_SYNC_WAIT:
            begin
                tcnt_next = '0;
                if (close_ok)
                begin
                    state_next = ST_CLOSE_PULSE;
                    pcnt_next = '0;
                end
                else if (tick_reg && pcnt_reg >= swait_reg)
                begin
                    state_next = ST_IDLE;
                    cancel_pulse = 1'b1;
                end
            end
            ST_CLOSE_PULSE, ST_OPEN_PULSE:
            begin
                if (dir_open_reg ? opened : closed)
                begin
                    state_next = ST_IDLE;
                end
                else if (tick_reg && pcnt_reg + 1'b1 >= (dir_open_reg ? omax_reg : cmax_reg))
                begin
                    state_next = ST_WAIT_POS;
                end
            end
            ST_WAIT_POS:
            begin
                if (dir_open_reg ? opened : closed)
                begin
                    state_next = ST_IDLE;
                end
                else if (tick_reg && tcnt_reg + 1'b1 >= term_reg)
                begin
                    state_next = ST_IDLE;
                    err_pulse = 1'b1;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // final trip
    // ****************************************
    logic trip_done;
    assign trip_done = dir_open_reg && opened &&
        (state_reg == ST_OPEN_PULSE || state_reg == ST_WAIT_POS);

    always_comb
    begin
        ft_next = o_final_trip;
        fcnt_next = fcnt_reg;
        if (trip_done && (!i_ar_in_control || !i_ar_reclose_expected))
        begin
            ft_next = 1'b1;
            fcnt_next = '0;
        end
        else if (state_next == ST_CLOSE_PULSE)
        begin
            // a held signal is released by the next close
            ft_next = 1'b0;
        end
        else if (o_final_trip && ftlen_reg != '0 && tick_reg)
        begin
            fcnt_next = fcnt_reg + 1'b1;
            ft_next = (fcnt_reg + 1'b1 < ftlen_reg);
        end
        // write one to clear; a new event in the same cycle is kept
        err_next = err_pulse | (err_reg & ~(i_wr_en && i_addr == `OC_ADDR_STATUS &&
            i_wr_data[`OC_STAT_ERR_BIT]));
        cancel_next = cancel_pulse | (cancel_reg & ~(i_wr_en && i_addr == `OC_ADDR_STATUS &&
            i_wr_data[`OC_STAT_CANCEL_BIT]));
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_reg <= `OC_CTRL_RST;
            trav_reg <= `OC_TIME_RST;
            swait_reg <= `OC_TIME_RST;
            cmax_reg <= `OC_TIME_RST;
            omax_reg <= `OC_TIME_RST;
            term_reg <= `OC_TERM_RST;
            ftlen_reg <= `OC_TIME_RST;
            omask_reg <= `OC_MASK_RST;
            cmask_reg <= `OC_MASK_RST;
            o_rd_data <= 32'h0000_0000;
            err_reg <= 1'b0;
            cancel_reg <= 1'b0;
            open_q_reg <= 1'b0;
            close_q_reg <= 1'b0;
            state_reg <= ST_IDLE;
            dir_open_reg <= 1'b0;
            pcnt_reg <= '0;
            tcnt_reg <= '0;
            fcnt_reg <= '0;
            o_open_cmd <= 1'b0;
            o_close_cmd <= 1'b0;
            o_final_trip <= 1'b0;
            o_ctrl_error <= 1'b0;
            o_sync_cancel <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            trav_reg <= trav_next;
            swait_reg <= swait_next;
            cmax_reg <= cmax_next;
            omax_reg <= omax_next;
            term_reg <= term_next;
            ftlen_reg <= ftlen_next;
            omask_reg <= omask_next;
            cmask_reg <= cmask_next;
            o_rd_data <= rd_next;
            err_reg <= err_next;
            cancel_reg <= cancel_next;
            open_q_reg <= open_req;
            close_q_reg <= close_req;
            state_reg <= state_next;
            dir_open_reg <= dir_open_next;
            pcnt_reg <= pcnt_next;
            tcnt_reg <= tcnt_next;
            fcnt_reg <= fcnt_next;
            o_open_cmd <= (state_next == ST_OPEN_PULSE);
            o_close_cmd <= (state_next == ST_CLOSE_PULSE);
            o_final_trip <= ft_next;
            o_ctrl_error <= err_pulse;
            o_sync_cancel <= cancel_pulse;
        end
    end

    position_monitor #(.TW(TW)) u_pos (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick_reg),
        .i_open_pos(i_open_pos),
        .i_closed_pos(i_closed_pos),
        .i_traverse(trav_reg),
        .o_status(o_brk_status)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_close_arrived;
        o_close_cmd && closed;
    endsequence
    property p_close_end;
        s_close_arrived |=> !o_close_cmd ##1 !o_close_cmd;
    endproperty
    a_close_end: assert property (p_close_end) else $error("close pulse not ended");

    property p_open_end;
        o_open_cmd && opened |=> !o_open_cmd;
    endproperty
    a_open_end: assert property (p_open_end) else $error("open pulse not ended");

    property p_sync_gate;
        $rose(o_close_cmd) && use_sync |-> $past(i_sync_ok);
    endproperty
    a_sync_gate: assert property (p_sync_gate) else $error("close without sync");

    property p_ready_gate;
        $rose(o_close_cmd) && rdy_mode == RDY_HIGH |-> $past(i_ready);
    endproperty
    a_ready_gate: assert property (p_ready_gate) else $error("close while not ready");

    sequence s_sync_expired;
        state_reg == ST_SYNC_WAIT && tick_reg && pcnt_reg >= swait_reg && !close_ok;
    endsequence
    property p_sync_timeout;
        s_sync_expired |=> o_sync_cancel && !o_close_cmd && state_reg == ST_IDLE
            ##1 !o_sync_cancel;
    endproperty
    a_sync_timeout: assert property (p_sync_timeout) else $error("sync wait not cancelled");

    property p_term;
        state_reg == ST_WAIT_POS && tick_reg && tcnt_reg + 1'b1 >= term_reg &&
            !(dir_open_reg ? opened : closed) |=> o_ctrl_error && state_reg == ST_IDLE;
    endproperty
    a_term: assert property (p_term) else $error("termination timeout missed");

    property p_ft_len;
        o_final_trip && ftlen_reg != '0 && tick_reg && fcnt_reg + 1'b1 >= ftlen_reg &&
            !trip_done |=> !o_final_trip;
    endproperty
    a_ft_len: assert property (p_ft_len) else $error("final trip too long");

    property p_ft_ar;
        $rose(o_final_trip) |-> $past(!i_ar_in_control || !i_ar_reclose_expected);
    endproperty
    a_ft_ar: assert property (p_ft_ar) else $error("final trip with reclose pending");

    property p_blocked;
        state_reg == ST_IDLE && open_rise && open_blocked && !close_rise |=> !o_open_cmd;
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked open executed");

endmodule : object_control
`default_nettype wire

// ### dv/breaker_model.sv
// circuit breaker model: coils in, position contacts out
`timescale 1ns/1ps
`default_nettype none

module breaker_model
#(
    parameter int DELAY = 10
)
(
    input wire logic i_sys_clk, // system clock
    input wire logic i_rst_n, // async reset, low active
    input wire logic i_open_coil, // open coil drive
    input wire logic i_close_coil, // close coil drive
    input wire logic i_stuck, // mechanism jams mid-travel, both contacts off
    output logic o_open_pos, // open contact
    output logic o_closed_pos // closed contact
);
    int cnt;

    // old contact lets go halfway through travel, new one makes at the end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= 0;
            o_open_pos <= 1'b0;
            o_closed_pos <= 1'b1;
        end
        else
        begin
            cnt <= ((i_open_coil || i_close_coil) && !(i_stuck && cnt == DELAY / 2)) ? cnt + 1 : 0;
            if (cnt == DELAY / 2)
            begin
                o_open_pos <= 1'b0;
                o_closed_pos <= 1'b0;
            end
            if (cnt == DELAY)
            begin
                o_open_pos <= i_open_coil;
                o_closed_pos <= i_close_coil;
            end
        end
    end
endmodule : breaker_model

`default_nettype wire

// ### dv/switchgear_object_control_tb_top.sv
// scenario testbench for object control
`timescale 1ns/1ps
`default_nettype none

module switchgear_object_control_tb_top
    import object_ctrl_pkg::*;
;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
    logic i_sync_ok = 1'b0, i_ready = 1'b1, stuck = 1'b0, ar = 1'b0;
    logic [7:0] i_addr = 8'h00, rq = 8'h00, i_close_lock = 8'h00, i_open_lock = 8'h00;
    logic [31:0] i_wr_data = 32'h0, o_rd_data;
    logic [1:0] i_sld_level = 2'h3;
    logic i_open_pos, i_closed_pos, o_open_cmd, o_close_cmd, o_final_trip, o_ctrl_error, o_sync_cancel;
    brk_status_t o_brk_status;
    int errors = 0, check_count = 0, n, m;

    // rq: local open/close, remote open/close, app open/close, diagram open/close
    object_control #(.TICK_CYCLES(4)) DUT (.i_sys_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr_en,
        .i_rd_en, .o_rd_data, .i_open_pos, .i_closed_pos, .i_ready, .i_sync_ok,
        .i_local_open(rq[0]), .i_local_close(rq[1]), .i_remote_open(rq[2]), .i_remote_close(rq[3]),
        .i_app_open(rq[4]), .i_app_close(rq[5]), .i_sld_open(rq[6]), .i_sld_close(rq[7]),
        .i_sld_level, .i_open_lock, .i_close_lock, .i_ar_in_control(ar),
        .i_ar_reclose_expected(ar), .o_open_cmd, .o_close_cmd, .o_brk_status, .o_final_trip,
        .o_ctrl_error, .o_sync_cancel);
    breaker_model brk (.i_sys_clk, .i_rst_n, .i_open_coil(o_open_cmd), .i_close_coil(o_close_cmd),
        .i_stuck(stuck), .o_open_pos(i_open_pos), .o_closed_pos(i_closed_pos));

    task summarize;
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wt(ref logic s, input logic v, output int k);
        for (k = 0; s !== v; k++)
        begin
            if (k > 500)
            begin
                errors++;
                summarize();
            end
            @(posedge i_sys_clk);
            #1;
        end
    endtask : wt

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        {i_addr, i_wr_data, i_wr_en} <= {a, d, 1'b1};
        @(posedge i_sys_clk);
        i_wr_en <= 1'b0;
    endtask : wr

    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        {i_addr, i_rd_en} <= {a, 1'b1};
        @(posedge i_sys_clk);
        i_rd_en <= 1'b0;
        #1 chk(nm, e, o_rd_data);
    endtask : rd

    // one request source pulsed high for two cycles
    task req(input int i);
        @(posedge i_sys_clk);
        rq[i] <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        rq[i] <= 1'b0;
        #1;
    endtask : req

    task t_op(input int i, input logic op);
        req(i);
        if (op) wt(o_open_cmd, 1'b1, n); else wt(o_close_cmd, 1'b1, n);
        chk("cmd latency", 1, n <= 2);
        if (op) wt(o_open_cmd, 1'b0, m); else wt(o_close_cmd, 1'b0, m);
        chk("pulse cut short", 1, m < 40);
        chk("status", op ? BRK_OPEN : BRK_CLOSED, o_brk_status);
        if (op) chk("final trip", !ar, o_final_trip);
        $display("test op %0d done", i);
    endtask : t_op

    task t_block;
        wr(8'h24, 32'h1);
        wr(8'h20, 32'h1);
        {i_open_lock, i_close_lock} <= 16'h0101;
        repeat (4) @(posedge i_sys_clk);
        m = 0;
        req(0);
        req(1);
        for (n = 0; n < 20; n++) @(posedge i_sys_clk) #1 m |= o_close_cmd;
        chk("blocked close", 0, m);
        {i_open_lock, i_close_lock} <= 16'h0000;
        $display("test block done");
    endtask : t_block

    task t_sync;
        wr(8'h00, 32'h13);
        req(3);
        wt(o_sync_cancel, 1'b1, n);
        chk("sync wait length", 1, n >= 66 && n <= 86);
        chk("no close pulse", 0, o_close_cmd);
        chk("final trip length", 0, o_final_trip);
        req(5);
        repeat (20) @(posedge i_sys_clk);
        {i_sync_ok, i_ready} <= 2'b10;
        #1 chk("close held", 0, o_close_cmd);
        repeat (8) @(posedge i_sys_clk);
        i_ready <= 1'b1;
        #1 chk("close not ready", 0, o_close_cmd);
        wt(o_close_cmd, 1'b1, n);
        chk("close after sync", 1, n <= 3);
        wt(o_close_cmd, 1'b0, n);
        chk("closed", BRK_CLOSED, o_brk_status);
        $display("test sync done");
    endtask : t_sync

    task t_stuck;
        stuck <= 1'b1;
        req(4);
        wt(o_ctrl_error, 1'b1, n);
        chk("termination time", 1, n >= 100 && n <= 130);
        chk("jammed status", BRK_INTERMEDIATE, o_brk_status);
        rd("status sticky", 8'h1c, 32'hc0);
        wr(8'h1c, 32'hc0);
        rd("status cleared", 8'h1c, 32'h00);
        $display("test stuck done");
    endtask : t_stuck

    initial
    begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    initial
    begin
        m = 0;
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd("ctrl reset", 8'h00, 32'h10);
        rd("unmapped", 8'h40, 32'h0);
        rd("status reset", 8'h1c, 32'h02);
        wr(8'h14, 32'd30);
        ar <= 1'b1;
        t_op(0, 1'b1);
        ar <= 1'b0;
        t_op(7, 1'b0);
        t_op(2, 1'b1);
        t_block();
        t_sync();
        t_stuck();
        summarize();
    end
endmodule : switchgear_object_control_tb_top

`default_nettype wire
